// [hdl/twacp_pkg.sv]
// Constants and types of the three-wire audio control port.
// Assumes a 25 MHz system clock and a single AHB-Lite master.
package twacp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int         CLK_PERIOD_NS = 40;
   localparam int         END_LOW_NS    = 3000;
   localparam logic [7:0] END_LOW_CYC   =
      8'((END_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Low cycles counted after the fall cycle itself
   localparam logic [7:0] END_LOW_LAST  = END_LOW_CYC - 8'h01;

   ////////////////////////////////////////////////////////////////////////////
   // Serial address space and functions
   localparam logic [4:0] ADDR_BASE_HI = 5'h08;
   localparam logic [2:0] FN_INPUT     = 3'h0;
   localparam logic [2:0] FN_LOUD      = 3'h1;
   localparam logic [2:0] FN_BASS      = 3'h2;
   localparam logic [2:0] FN_TREBLE    = 3'h3;
   localparam logic [2:0] FN_VOL_L     = 3'h4;
   localparam logic [2:0] FN_VOL_R     = 3'h5;
   localparam logic [2:0] FN_MODE      = 3'h6;
   localparam logic [2:0] FN_READ      = 3'h7;
   localparam logic [3:0] BITS_PER_HALF = 4'h8;
   localparam logic [3:0] READ_SLOT_HI  = 4'h6;
   localparam logic [3:0] READ_SLOT_LO  = 4'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Setting levels
   localparam logic [3:0] TONE_MAX   = 4'hc;
   localparam logic [3:0] TONE_FLAT  = 4'h6;
   localparam logic [5:0] VOL_MIN    = 6'h28;
   localparam logic [1:0] INPUT_MUTE = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Synchroniser lanes
   localparam int SYN_CLK   = 0;
   localparam int SYN_FRAME = 1;
   localparam int SYN_DATA  = 2;
   localparam int SYN_PIN_A = 3;
   localparam int SYN_PIN_B = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_SETTINGS = 8'h04;
   localparam logic [7:0] REG_STATUS   = 8'h08;
   localparam int         CTRL_EN_BIT  = 0;
   localparam logic       CTRL_EN_RST  = 1'b1;

   typedef enum logic [1:0] {TWACP_MONO_L, TWACP_STEREO, TWACP_MONO_R} twacp_mode_t;

   typedef struct packed {
      twacp_mode_t mode;
      logic [5:0]  vol_r;
      logic [5:0]  vol_l;
      logic [3:0]  treble;
      logic [3:0]  bass;
      logic        loudness;
      logic [1:0]  input_sel;
   } twacp_settings_t;

   localparam twacp_settings_t SETTINGS_RST = '{TWACP_STEREO, VOL_MIN, VOL_MIN,
                                               TONE_FLAT, TONE_FLAT, 1'b0, INPUT_MUTE};

endpackage

// [hdl/twacp_top.sv]
// Serial control port with function latches and an AHB-Lite register view.
// Assumes serial pins are asynchronous to CLK_SYS and far slower than it.
// Function
// - Clock and frame-select are inputs; data line driven only open-drain.
// - Only addresses 40h to 47h are taken; others are ignored.
// - Address bits are sampled on rising serial clock edges.
// - Eight more clocks shift data in or read inputs out.
// - Frame-select low pulse of at least 3 us latches the data.
// - Volume and tone codes are plain binary steps.
// - Don't-care data bits have no effect on the setting.
// - One 16-bit transfer or two 8-bit transfers are accepted.
// - Last 8 bits while low are address; last 8 while high are data.
// - Latches hold until the end pulse copies data into the addressed one.
// - Digital input levels are latched and returned by the read function.
// - Returned input bits are active low, pins idle high.
// - Input select codes 00, 01, 10, 11 give inputs one to three, mute.
// - Tone codes step binary; any 11xx code saturates at maximum boost.
// - Volume codes step binary; 101xxx and 11xxxx give full attenuation.
// - Mode 100 left mono, 101 stereo, 11x right mono.
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module twacp_top
(
   // System
   input  wire logic                      CLK_SYS,
   input  wire logic                      RST,
   // AHB-Lite slave
   input  wire logic                      HSEL,
   input  wire logic [31:0]               HADDR,
   input  wire logic [1:0]                HTRANS,
   input  wire logic                      HWRITE,
   input  wire logic [2:0]                HSIZE,
   input  wire logic [31:0]               HWDATA,
   input  wire logic                      HREADY,
   output logic                           HREADYOUT,
   output logic [31:0]                    HRDATA,
   output logic                           HRESP,
   // Serial link
   input  wire logic                      SER_CLK,
   input  wire logic                      FRAME_SELECT_LINE,
   input  wire logic                      SER_DATA_I,
   output logic                           SER_DATA_O,
   output logic                           SER_DATA_OE,
   // Digital inputs, active low
   input  wire logic                      STATUS_BIT_A,
   input  wire logic                      STATUS_BIT_B,
   // Decoded function settings
   output twacp_pkg::twacp_settings_t     SETTINGS
);
   import twacp_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_END} twacp_state_t;

   twacp_state_t    state;
   twacp_state_t    next_state;
   logic [4:0]      sync1;
   logic [4:0]      sync2;
   logic [4:0]      sync3;
   logic            sclk_rise;
   logic            frame_fall;
   logic            frame_rise;
   logic            data_in;
   logic [7:0]      addr_sr;
   logic [7:0]      data_sr;
   logic [3:0]      bit_cnt;
   logic [7:0]      low_cnt;
   logic            addr_ok;
   logic [2:0]      fn;
   logic            read_sel;
   logic            latch_pulse;
   logic [1:0]      snap;
   logic            next_oe;
   logic            port_enable;
   twacp_settings_t settings;
   logic            wr_pend;
   logic [7:0]      wr_off;
   logic            ahb_go;
   logic [31:0]     rd_word;

   // Tone step saturates at maximum boost
   function automatic logic [3:0] tone_sat(input logic [3:0] d);
      tone_sat = (d[3:2] == 2'b11) ? TONE_MAX : d;
   endfunction

   // Volume step saturates at full attenuation
   function automatic logic [5:0] vol_sat(input logic [5:0] d);
      vol_sat = (d[5] && (d[4] || d[3])) ? VOL_MIN : d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         sync1 <= 5'h1f;
         sync2 <= 5'h1f;
         sync3 <= 5'h1f;
      end
      else
      begin
         sync1 <= {STATUS_BIT_B, STATUS_BIT_A, SER_DATA_I, FRAME_SELECT_LINE, SER_CLK};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Edges seen on the second stage only
   assign sclk_rise  = sync2[SYN_CLK] & ~sync3[SYN_CLK];
   assign frame_fall = ~sync2[SYN_FRAME] & sync3[SYN_FRAME];
   assign frame_rise = sync2[SYN_FRAME] & ~sync3[SYN_FRAME];
   assign data_in    = sync2[SYN_DATA];

   ////////////////////////////////////////////////////////////////////////////
   // Transfer sequencer
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE: if (frame_fall) next_state = ST_ADDR;
         ST_ADDR: if (frame_rise) next_state = ST_DATA;
         ST_DATA: if (frame_fall)
                     next_state = (bit_cnt >= BITS_PER_HALF) ? ST_END : ST_ADDR;
         ST_END:  if (sclk_rise) next_state = ST_ADDR;
                  else if (frame_rise) next_state = ST_IDLE;
      endcase
      if (!port_enable)
         next_state = ST_IDLE;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Address shifter keeps the last eight bits seen while frame-select is low
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         addr_sr <= 8'h00;
      else if (sclk_rise && (state == ST_ADDR || state == ST_END))
         addr_sr <= {addr_sr[6:0], data_in};
   end

   // Data shifter and bit count of the value half
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         data_sr <= 8'h00;
         bit_cnt <= 4'h0;
      end
      else if (state == ST_ADDR && frame_rise)
         bit_cnt <= 4'h0;
      else if (state == ST_DATA && sclk_rise)
      begin
         data_sr <= {data_sr[6:0], data_in};
         if (bit_cnt < BITS_PER_HALF)
            bit_cnt <= bit_cnt + 4'h1;
      end
   end

   // Width of the end pulse
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         low_cnt <= 8'h00;
      else if (state == ST_END && !sync2[SYN_FRAME])
      begin
         if (low_cnt < END_LOW_LAST)
            low_cnt <= low_cnt + 8'h01;
      end
      else
         low_cnt <= 8'h00;
   end

   assign addr_ok     = (addr_sr[7:3] == ADDR_BASE_HI);
   assign fn          = addr_sr[2:0];
   assign read_sel    = addr_ok && (fn == FN_READ);
   assign latch_pulse = (state == ST_END) && frame_rise && port_enable
                        && addr_ok && (low_cnt >= END_LOW_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // Function latches
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         settings <= SETTINGS_RST;
      else if (latch_pulse)
      begin
         unique case (fn)
            FN_INPUT:  settings.input_sel <= data_sr[1:0];
            FN_LOUD:   settings.loudness  <= data_sr[0];
            FN_BASS:   settings.bass      <= tone_sat(data_sr[3:0]);
            FN_TREBLE: settings.treble    <= tone_sat(data_sr[3:0]);
            FN_VOL_L:  settings.vol_l     <= vol_sat(data_sr[5:0]);
            FN_VOL_R:  settings.vol_r     <= vol_sat(data_sr[5:0]);
            FN_MODE:
               if (data_sr[2])
                  settings.mode <= data_sr[1] ? TWACP_MONO_R :
                                   (data_sr[0] ? TWACP_STEREO : TWACP_MONO_L);
            FN_READ:   settings <= settings;
         endcase
      end
   end

   assign SETTINGS = settings;

   ////////////////////////////////////////////////////////////////////////////
   // Digital input read-back
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         snap <= 2'b11;
      else if (state == ST_ADDR && frame_rise && read_sel)
         snap <= {sync2[SYN_PIN_B], sync2[SYN_PIN_A]};
   end

   // Open-drain drive: pull low only for a zero bit in the two read slots
   assign next_oe = (state == ST_DATA) && read_sel && port_enable
                    && (bit_cnt >= READ_SLOT_HI) && (bit_cnt <= READ_SLOT_LO)
                    && !((bit_cnt == READ_SLOT_HI) ? snap[1] : snap[0]);

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         SER_DATA_OE <= 1'b0;
      else
         SER_DATA_OE <= next_oe;
   end

   assign SER_DATA_O = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   assign ahb_go    = HSEL && HTRANS[1] && HREADY;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   always_comb
   begin
      rd_word = 32'h0;
      if (HADDR[31:8] == 24'h0)
      begin
         unique case (HADDR[7:0])
            REG_CTRL:     rd_word = {31'h0, port_enable};
            REG_SETTINGS: rd_word = {7'h0, settings};
            REG_STATUS:   rd_word = {20'h0, state != ST_IDLE, sync2[SYN_PIN_B],
                                     sync2[SYN_PIN_A], addr_ok, addr_sr};
            default:      rd_word = 32'h0;
         endcase
      end
   end

   // Address phase capture and read data
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         wr_pend <= 1'b0;
         wr_off  <= 8'h00;
         HRDATA  <= 32'h0;
      end
      else
      begin
         wr_pend <= ahb_go && HWRITE && (HADDR[31:8] == 24'h0);
         wr_off  <= HADDR[7:0];
         if (ahb_go && !HWRITE)
            HRDATA <= rd_word;
      end
   end

   // Control register write in the data phase
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         port_enable <= CTRL_EN_RST;
      else if (wr_pend && wr_off == REG_CTRL)
         port_enable <= HWDATA[CTRL_EN_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_od_drive;
      @(posedge CLK_SYS) disable iff (RST)
      SER_DATA_OE |-> (SER_DATA_O == 1'b0) && ($past(state) == ST_DATA) && $past(read_sel);
   endproperty
   a_od_drive: assert property (p_od_drive) else $error("data line driven out of slot");

   property p_bad_addr;
      @(posedge CLK_SYS) disable iff (RST)
      (state == ST_END && frame_rise && !addr_ok) |=> $stable(settings);
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("foreign address changed setting");

   property p_addr_shift;
      @(posedge CLK_SYS) disable iff (RST)
      (sclk_rise && state == ST_ADDR) |=> addr_sr == {$past(addr_sr[6:0]), $past(data_in)};
   endproperty
   a_addr_shift: assert property (p_addr_shift) else $error("address bit not sampled");

   property p_end_width;
      @(posedge CLK_SYS) disable iff (RST)
      latch_pulse |-> !$past(sync2[SYN_FRAME]) && !$past(sync2[SYN_FRAME], 75);
   endproperty
   a_end_width: assert property (p_end_width) else $error("latched on short end pulse");

   property p_hold;
      @(posedge CLK_SYS) disable iff (RST)
      !latch_pulse |=> $stable(settings);
   endproperty
   a_hold: assert property (p_hold) else $error("setting changed without end pulse");

   property p_read_lo;
      @(posedge CLK_SYS) disable iff (RST)
      (state == ST_DATA && read_sel && port_enable && bit_cnt == READ_SLOT_LO)
      |=> SER_DATA_OE == !$past(snap[0]);
   endproperty
   a_read_lo: assert property (p_read_lo) else $error("input bit A returned wrongly");

   property p_bass_sat;
      @(posedge CLK_SYS) disable iff (RST)
      (latch_pulse && fn == FN_BASS && data_sr[3:2] == 2'b11) |=> settings.bass == 4'hc;
   endproperty
   a_bass_sat: assert property (p_bass_sat) else $error("bass not saturated");

   property p_vol_sat;
      @(posedge CLK_SYS) disable iff (RST)
      (latch_pulse && fn == FN_VOL_L && data_sr[5:4] == 2'b11) |=> settings.vol_l == 6'h28;
   endproperty
   a_vol_sat: assert property (p_vol_sat) else $error("volume not saturated");

   property p_reset_val;
      @(posedge CLK_SYS)
      $past(RST) |-> settings.vol_l == 6'h28 && settings.bass == 4'h6
                     && settings.input_sel == 2'h3 && !settings.loudness;
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("wrong power-up setting");
endmodule

// [sim/twacp_host.sv]
// Host controller model for the three-wire control bus.
// Assumes a pull-up on the data line and the device's open-drain enable.
`timescale 1ns/1ps
module twacp_host
(
   // Bus lines
   output logic      ser_clk,
   output logic      frame,
   output wire logic data_wire,
   // Device drive
   input  wire logic dev_oe
);
   logic       host_drv;
   logic [7:0] rd_byte;

   // Wired-AND of host drive and device pull-down, idle high
   assign data_wire = host_drv & ~dev_oe;

   // All lines rest high outside frames
   initial
   begin
      ser_clk  = 1'b1;
      frame    = 1'b1;
      host_drv = 1'b1;
      rd_byte  = 8'h00;
   end

   // One bit, valid at the rising clock, wire sampled there
   task automatic bit_out(input logic b);
      ser_clk  = 1'b0;
      host_drv = b;
      #160;
      ser_clk  = 1'b1;
      rd_byte  = {rd_byte[6:0], data_wire};
      #160;
   endtask

   // Whole transfer: optional leading byte, address, value, end pulse
   task automatic xfer(input logic [7:0] pre, input logic pre_en, input logic [7:0] adr,
                       input logic [7:0] val, input int end_ns);
      #10; // Step off the system clock edge
      frame   = 1'b0;
      ser_clk = 1'b0;
      #160;
      if (pre_en)
         for (int i = 7; i >= 0; i--)
            bit_out(pre[i]);
      for (int i = 7; i >= 0; i--)
         bit_out(adr[i]);
      frame = 1'b1;
      for (int i = 7; i >= 0; i--)
         bit_out(val[i]);
      host_drv = 1'b1;
      #160;
      frame = 1'b0;
      #(end_ns);
      frame = 1'b1;
      #640;
   endtask

   // Two address and value pairs in one frame, a single end pulse at the close
   task automatic xfer_pair(input logic [7:0] adr1, input logic [7:0] val1,
                            input logic [7:0] adr2, input logic [7:0] val2);
      #10; // Step off the system clock edge
      frame   = 1'b0;
      ser_clk = 1'b0;
      #160;
      for (int i = 7; i >= 0; i--)
         bit_out(adr1[i]);
      frame = 1'b1;
      for (int i = 7; i >= 0; i--)
         bit_out(val1[i]);
      frame = 1'b0;
      for (int i = 7; i >= 0; i--)
         bit_out(adr2[i]);
      frame = 1'b1;
      for (int i = 7; i >= 0; i--)
         bit_out(val2[i]);
      host_drv = 1'b1;
      #160;
      frame = 1'b0;
      #3200;
      frame = 1'b1;
      #640;
   endtask
endmodule

// [sim/twacp_top_test.sv]
// Self-checking bench of the control port: serial host plus AHB-Lite master.
// Assumes the host model owns the link and the bus always answers OKAY.
`timescale 1ns/1ps
module twacp_top_test;
   import twacp_pkg::*;
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
   logic            clk;
   logic            rst;
   logic            hsel;
   logic [31:0]     haddr;
   logic [1:0]      htrans;
   logic            hwrite;
   logic [31:0]     hwdata;
   logic            hready;
   logic [31:0]     hrdata;
   logic            hresp;
   logic            ser_clk;
   logic            frame;
   wire logic       dwire;
   logic            dout;
   logic            doe;
   logic            pin_a;
   logic            pin_b;
   twacp_settings_t settings;
   logic [31:0]     rd;
   int              err_count;
   int              cmp_count;

   ////////////////////////////////////////
   // Design, host and clock
   twacp_top DUT (.CLK_SYS(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
      .HRDATA(hrdata), .HRESP(hresp), .SER_CLK(ser_clk), .FRAME_SELECT_LINE(frame),
      .SER_DATA_I(dwire), .SER_DATA_O(dout), .SER_DATA_OE(doe), .STATUS_BIT_A(pin_a),
      .STATUS_BIT_B(pin_b), .SETTINGS(settings));
   twacp_host host (.ser_clk(ser_clk), .frame(frame), .data_wire(dwire), .dev_oe(doe));
   always #20 clk = ~clk;

   ////////////////////////////////////////
   // Shared tasks
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   // Single word transfer; read data taken at the end of the data phase
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask

   task automatic wr(input logic [2:0] f, input logic [7:0] v);
      host.xfer(8'h00, 1'b0, {ADDR_BASE_HI, f}, v, 3200);
   endtask

   task automatic close_out();
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   ////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      `CHK("settings", SETTINGS_RST, settings);
      ahb(1'b0, REG_SETTINGS, 32'h0);
      `CHK("settings_reg", {7'h0, SETTINGS_RST}, rd);
      ahb(1'b0, REG_CTRL, 32'h0);
      `CHK("ctrl", 1'b1, rd[0]);
   endtask

   task automatic t_codes();
      logic [3:0] tc [6] = '{4'h0, 4'h3, 4'h6, 4'h9, 4'hc, 4'hf};
      logic [3:0] te [6] = '{4'h0, 4'h3, 4'h6, 4'h9, 4'hc, 4'hc};
      logic [5:0] vc [5] = '{6'h00, 6'h14, 6'h2c, 6'h30, 6'h3f};
      logic [5:0] ve [5] = '{6'h00, 6'h14, 6'h28, 6'h28, 6'h28};
      logic [2:0] mc [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
      logic [1:0] me [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
      for (int i = 0; i < 4; i++)
      begin
         wr(FN_INPUT, 8'hfc | 8'(i));
         `CHK("input_sel", i[1:0], settings.input_sel);
      end
      for (int i = 0; i < 6; i++)
      begin
         wr(FN_BASS, {4'ha, tc[i]});
         `CHK("bass", te[i], settings.bass);
         wr(FN_TREBLE, {4'h5, tc[i]});
         `CHK("treble", te[i], settings.treble);
      end
      for (int i = 0; i < 5; i++)
      begin
         wr(FN_VOL_L, {2'h3, vc[i]});
         `CHK("vol_l", ve[i], settings.vol_l);
         wr(FN_VOL_R, {2'h2, vc[i]});
         `CHK("vol_r", ve[i], settings.vol_r);
         wr(FN_MODE, {5'h1f, mc[i]});
         `CHK("mode", me[i], settings.mode);
      end
      wr(FN_LOUD, 8'h01);
      `CHK("loud_on", 1'b1, settings.loudness);
      wr(FN_LOUD, 8'hfe);
      `CHK("loud_off", 1'b0, settings.loudness);
   endtask

   task automatic t_refuse();
      wr(FN_INPUT, 8'h01);
      host.xfer(8'h00, 1'b0, 8'h48, 8'h00, 3200);
      `CHK("bad_addr", 2'h1, settings.input_sel);
      ahb(1'b0, REG_STATUS, 32'h0);
      `CHK("status_addr", 9'h048, rd[8:0]);
      `CHK("status_idle", 1'b0, rd[11]);
      wr(FN_INPUT, 8'h00);
      host.xfer(8'h00, 1'b0, 8'h40, 8'h03, 2880);
      `CHK("short_end", 2'h0, settings.input_sel);
      host.xfer(8'h44, 1'b1, 8'h40, 8'h02, 3040);
      `CHK("two_byte", 2'h2, settings.input_sel);
      `CHK("vol_kept", 6'h28, settings.vol_l);
   endtask

   task automatic t_read();
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk);
         pin_a <= i[0];
         pin_b <= ~i[0];
         repeat (8) @(posedge clk);
         host.xfer(8'h00, 1'b0, 8'h47, 8'hff, 3200);
         `CHK("read_byte", {6'h3f, ~i[0], i[0]}, host.rd_byte);
         `CHK("read_keeps", 2'h2, settings.input_sel);
         ahb(1'b0, REG_STATUS, 32'h0);
         `CHK("status_pins", {~i[0], i[0], 1'b1}, rd[10:8]);
      end
   endtask

   task automatic t_bus();
      ahb(1'b1, REG_CTRL, 32'h0);
      wr(FN_INPUT, 8'h00);
      `CHK("disabled", 2'h2, settings.input_sel);
      ahb(1'b1, REG_SETTINGS, 32'h0);
      ahb(1'b0, 8'h0c, 32'h0);
      `CHK("unmapped", 32'h0, rd);
      `CHK("hresp", 1'b0, hresp);
      `CHK("hreadyout", 1'b1, hready);
      `CHK("data_o", 1'b0, dout);
      ahb(1'b1, REG_CTRL, 32'h1);
      ahb(1'b0, REG_SETTINGS, 32'h0);
      `CHK("ro_reg", 2'h2, rd[1:0]);
      wr(FN_INPUT, 8'h00);
      `CHK("enabled", 2'h0, settings.input_sel);
   endtask

   // Two pairs in one frame: only the last address and value are latched
   task automatic t_pair();
      host.xfer_pair({ADDR_BASE_HI, FN_BASS}, 8'h00, {ADDR_BASE_HI, FN_TREBLE}, 8'h09);
      `CHK("pair_first", TONE_MAX, settings.bass);
      `CHK("pair_last", 4'h9, settings.treble);
   endtask

   // Reset in mid-run brings back the power-up settings and the enable
   task automatic t_rerst();
      ahb(1'b1, REG_CTRL, 32'h0);
      @(posedge clk);
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("rerst_settings", SETTINGS_RST, settings);
      ahb(1'b0, REG_CTRL, 32'h0);
      `CHK("rerst_ctrl", CTRL_EN_RST, rd[CTRL_EN_BIT]);
   endtask

   ////////////////////////////////////////
   // Main sequence and watchdog
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      pin_a = 1'b1;
      pin_b = 1'b1;
      err_count = 0;
      cmp_count = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_reset();
      t_codes();
      t_refuse();
      t_read();
      t_bus();
      t_pair();
      t_rerst();
      close_out();
   end

   initial
   begin
      #1000000;
      err_count++;
      close_out();
   end
endmodule
